// [flash_fault_pkg.sv]
// constants, types and register map for the flash fault supervisor
// Operation
// - output overvoltage shuts down, sets fault bit 7, holds off until cleared
// - missing output capacitor on an enabled event sets fault bit 7, holds off
// - overvoltage and missing capacitor share fault bit 7, no separate flag
// - pin mode: both enables high past 850 ms locks off until both enables and torch are low
// - level strobe active past 850 ms sets fault bit 4 and disables
// - overtemperature shuts down, sets fault bit 5, holds off until cleared
// - led output below short threshold through startup sets fault bit 6
// - inductor peak limit comes from output mode bits 7:6
// - peak current over limit shuts down, sets fault bit 1, holds off
// - in serial mode led count detection runs only with output mode bit 3
// - event start with detection forces the fixed detection current while sampling
// - forward voltage above threshold during detection sets fault register bit 3
// - undervoltage lockout shuts down and returns every register to default
// - in serial mode, reading the fault register clears fault flags and re-enables the device
// - input control bit 2 selects strobe polarity, set means high or rising
`default_nettype none
package flash_fault_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ       = 200;
    localparam int CLK_PERIOD_NS = 5;
    localparam int TIMEOUT_MS    = 850;
    localparam int TIMEOUT_CYC   = TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam int STARTUP_NS    = 1000;
    localparam int STARTUP_CYC   = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W         = 28;
    localparam int STUP_W        = 8;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_OUT_MODE = 8'h04;
    localparam logic [7:0] ADDR_FAULT    = 8'h05;
    localparam logic [7:0] ADDR_IN_CTRL  = 8'h06;
    localparam int OM_ILIM_HI   = 7;
    localparam int OM_ILIM_LO   = 6;
    localparam int OM_LEVEL     = 5;
    localparam int OM_TORCH_OK  = 4;
    localparam int OM_DETECT    = 3;
    localparam int OM_STROBE_EN = 2;
    localparam int OM_MODE_HI   = 1;
    localparam int OM_MODE_LO   = 0;
    localparam int FI_OVP       = 7;
    localparam int FI_SHORT     = 6;
    localparam int FI_TEMP      = 5;
    localparam int FI_TIMEOUT   = 4;
    localparam int FI_TWO_LED   = 3;
    localparam int FI_ILIM      = 1;
    localparam int IC_POL       = 2;
    localparam logic [7:0] OUT_MODE_RST   = 8'hb4;
    localparam logic [7:0] FAULT_RST      = 8'h08;
    localparam logic [7:0] IN_CTRL_RST    = 8'h06;
    localparam logic [7:0] FAULT_CLR_MASK = 8'hf2;
    localparam logic [7:0] IN_CTRL_MASK   = 8'h06;
    localparam logic [1:0] MODE_STANDBY   = 2'h0;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic ovp;           // output above overvoltage threshold
        logic cout_missing;  // no output capacitor detected
        logic over_temp;     // junction above thermal limit
        logic led_short;     // led output below short threshold
        logic ilim_trip;     // inductor peak above limit
        logic vf_high;       // forward voltage above two-led threshold
    } sense_s;
    typedef struct packed {
        logic flash_enable_a;
        logic flash_enable_b;
        logic torch;
        logic strobe;
    } pins_s;
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } reg_req_s;
    typedef enum logic [1:0] {
        PH_IDLE  = 2'b00,
        PH_START = 2'b01,
        PH_RUN   = 2'b10
    } phase_e;
endpackage
`default_nettype wire

// [flash_fault_protection.sv]
// fault supervision, flash timeout and led count detection for the flash driver
`timescale 1ns/10ps
`default_nettype none
module flash_fault_protection #(
    parameter int TIMEOUT_CYCLES = flash_fault_pkg::TIMEOUT_CYC  // flash duration limit in clocks
) (
    input  wire logic                      clock_in,          // 200 MHz core clock
    input  wire logic                      sys_rst_in,        // power-on reset, sync, high
    input  wire logic                      clk_en_in,         // freezes all state when low
    input  wire logic                      input_undervoltage_lockout_in, // battery low, high
    input  wire logic                      serial_mode_in,    // high: serial register mode
    input  wire flash_fault_pkg::pins_s    pins_in,           // enable, torch and strobe pins
    input  wire flash_fault_pkg::sense_s   sense_in,          // analog comparator results
    input  wire flash_fault_pkg::reg_req_s reg_req_in,        // register access from serial slave
    output logic [7:0]                     reg_rdata_out,     // read data, held until next read
    output logic                           driver_enable_out, // boost and led source enable
    output logic                           detect_drive_out,  // force detection current
    output logic [1:0]                     ilim_sel_out,      // inductor peak limit code
    output logic [7:0]                     fault_flags_out    // live fault register
);
    import flash_fault_pkg::*;

    // ------------------------------------------------------------
    // decode helper
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]        out_mode_reg, out_mode_next;
    logic [7:0]        fault_reg, fault_next;
    logic [7:0]        in_ctrl_reg, in_ctrl_next;
    logic [7:0]        rdata_reg, rdata_next;
    logic              pin_lock_reg, pin_lock_next;
    logic              drv_en_reg, drv_en_next;
    logic              det_drv_reg, det_drv_next;
    logic              edge_latch_reg, edge_latch_next;
    logic              strobe_q_reg, strobe_q_next;
    logic              short_all_reg, short_all_next;
    logic              vf_seen_reg, vf_seen_next;
    logic [TMR_W-1:0]  tmr_reg, tmr_next;
    logic [STUP_W-1:0] stup_reg, stup_next;
    phase_e            phase_reg, phase_next;

    logic       rst;
    logic       strobe_act;
    logic       strobe_rise;
    logic       request;
    logic       timed_req;
    logic       timeout_hit;
    logic       disabled;
    logic       detect_on;
    logic       all_low;
    logic [7:0] set_bits;
    logic [7:0] clr_bits;

    // lockout wipes registers exactly like power-on reset
    assign rst = sys_rst_in | input_undervoltage_lockout_in;

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    always_comb begin
        // polarity bit picks the active strobe level and edge
        strobe_act  = in_ctrl_reg[IC_POL] ? pins_in.strobe : ~pins_in.strobe;
        strobe_rise = strobe_act & ~strobe_q_reg;
        all_low     = ~pins_in.flash_enable_a & ~pins_in.flash_enable_b & ~pins_in.torch;
        if (serial_mode_in) begin
            request = (out_mode_reg[OM_MODE_HI:OM_MODE_LO] != MODE_STANDBY)
                    | (out_mode_reg[OM_TORCH_OK] & pins_in.torch)
                    | (out_mode_reg[OM_STROBE_EN] &
                       (out_mode_reg[OM_LEVEL] ? strobe_act : edge_latch_reg));
            timed_req = out_mode_reg[OM_STROBE_EN] & out_mode_reg[OM_LEVEL] & strobe_act;
            detect_on = out_mode_reg[OM_DETECT];
        end else begin
            request   = pins_in.flash_enable_a | pins_in.flash_enable_b | pins_in.torch;
            timed_req = pins_in.flash_enable_a & pins_in.flash_enable_b;
            detect_on = 1'b1;
        end
        timeout_hit = (tmr_reg == TMR_W'(TIMEOUT_CYCLES - 1));
        disabled    = (|(fault_reg & FAULT_CLR_MASK)) | pin_lock_reg;
    end

    // ------------------------------------------------------------
    // next state: registers, faults, timer, startup phase
    // ------------------------------------------------------------
    always_comb begin
        out_mode_next   = out_mode_reg;
        in_ctrl_next    = in_ctrl_reg;
        rdata_next      = rdata_reg;
        pin_lock_next   = pin_lock_reg;
        edge_latch_next = edge_latch_reg;
        strobe_q_next   = strobe_act;
        short_all_next  = short_all_reg;
        vf_seen_next    = vf_seen_reg;
        stup_next       = stup_reg;
        phase_next      = phase_reg;
        set_bits        = 8'h00;
        clr_bits        = 8'h00;

        // timer clears whenever the timed request drops
        if (!timed_req) begin
            tmr_next = '0;
        end else if (timeout_hit) begin
            tmr_next = tmr_reg;
        end else begin
            tmr_next = tmr_reg + TMR_W'(1);
        end

        // edge mode strobe starts a flash that stays until a fault or until edge mode is left
        if (strobe_rise && out_mode_reg[OM_STROBE_EN] && !out_mode_reg[OM_LEVEL]) begin
            edge_latch_next = 1'b1;
        end

        // comparators only latch while the driver is running, except heat and overvoltage
        if (sense_in.ovp) set_bits[FI_OVP] = 1'b1;
        if (drv_en_reg && sense_in.cout_missing) set_bits[FI_OVP] = 1'b1;
        if (sense_in.over_temp) set_bits[FI_TEMP] = 1'b1;
        if (drv_en_reg && sense_in.ilim_trip) set_bits[FI_ILIM] = 1'b1;
        if (timed_req && timeout_hit) begin
            if (serial_mode_in) begin
                set_bits[FI_TIMEOUT] = 1'b1;
            end else begin
                pin_lock_next = 1'b1;
            end
        end

        // startup window: detection current plus short and forward voltage sampling
        case (phase_reg)
            PH_IDLE: begin
                if (request && !disabled) begin
                    phase_next     = PH_START;
                    stup_next      = '0;
                    short_all_next = 1'b1;
                    vf_seen_next   = 1'b0;
                end
            end
            PH_START: begin
                short_all_next = short_all_reg & sense_in.led_short;
                vf_seen_next   = vf_seen_reg | sense_in.vf_high;
                if (!request || disabled) begin
                    phase_next = PH_IDLE;
                end else if (stup_reg == STUP_W'(STARTUP_CYC - 1)) begin
                    phase_next = PH_RUN;
                    if (short_all_reg && sense_in.led_short) set_bits[FI_SHORT] = 1'b1;
                end else begin
                    stup_next = stup_reg + STUP_W'(1);
                end
            end
            PH_RUN: begin
                if (!request || disabled) phase_next = PH_IDLE;
            end
            default: phase_next = PH_IDLE;
        endcase

        // register port; in serial mode reading the fault register clears its flags
        if (reg_req_in.wr) begin
            if (hit(reg_req_in.addr, ADDR_OUT_MODE)) out_mode_next = reg_req_in.wdata;
            if (hit(reg_req_in.addr, ADDR_IN_CTRL)) in_ctrl_next = reg_req_in.wdata & IN_CTRL_MASK;
        end
        if (reg_req_in.rd) begin
            if (hit(reg_req_in.addr, ADDR_OUT_MODE)) rdata_next = out_mode_reg;
            else if (hit(reg_req_in.addr, ADDR_FAULT)) rdata_next = fault_reg;
            else if (hit(reg_req_in.addr, ADDR_IN_CTRL)) rdata_next = in_ctrl_reg;
            else rdata_next = 8'h00;
            if (serial_mode_in && hit(reg_req_in.addr, ADDR_FAULT)) clr_bits = FAULT_CLR_MASK;
        end
        // pin mode reads do not clear flags, so both enables and torch low is the clear
        if (!serial_mode_in && all_low) begin
            clr_bits      = FAULT_CLR_MASK;
            pin_lock_next = 1'b0;
        end

        // set wins over clear so no fault is lost in a clearing read
        fault_next = (fault_reg & ~clr_bits) | set_bits;
        if (reg_req_in.wr && hit(reg_req_in.addr, ADDR_FAULT)) begin
            fault_next[FI_TWO_LED] = reg_req_in.wdata[FI_TWO_LED];
        end
        if (phase_reg == PH_START && stup_reg == STUP_W'(STARTUP_CYC - 1) && detect_on) begin
            fault_next[FI_TWO_LED] = vf_seen_reg | sense_in.vf_high;
        end
        // a latched edge must not outlive edge mode, or re-enabling strobe would fire a stale flash
        if (disabled || !out_mode_reg[OM_STROBE_EN] || out_mode_reg[OM_LEVEL]) edge_latch_next = 1'b0;

        // outputs: any latched fault or pin lock keeps the driver off
        drv_en_next  = request & ~disabled & ~(|set_bits) & ~pin_lock_next;
        det_drv_next = drv_en_next & detect_on & (phase_next == PH_START);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (rst) begin
            out_mode_reg   <= OUT_MODE_RST;
            fault_reg      <= FAULT_RST;
            in_ctrl_reg    <= IN_CTRL_RST;
            rdata_reg      <= 8'h00;
            pin_lock_reg   <= 1'b0;
            drv_en_reg     <= 1'b0;
            det_drv_reg    <= 1'b0;
            edge_latch_reg <= 1'b0;
            strobe_q_reg   <= 1'b0;
            short_all_reg  <= 1'b0;
            vf_seen_reg    <= 1'b0;
            tmr_reg        <= '0;
            stup_reg       <= '0;
            phase_reg      <= PH_IDLE;
        end else if (clk_en_in) begin
            out_mode_reg   <= out_mode_next;
            fault_reg      <= fault_next;
            in_ctrl_reg    <= in_ctrl_next;
            rdata_reg      <= rdata_next;
            pin_lock_reg   <= pin_lock_next;
            drv_en_reg     <= drv_en_next;
            det_drv_reg    <= det_drv_next;
            edge_latch_reg <= edge_latch_next;
            strobe_q_reg   <= strobe_q_next;
            short_all_reg  <= short_all_next;
            vf_seen_reg    <= vf_seen_next;
            tmr_reg        <= tmr_next;
            stup_reg       <= stup_next;
            phase_reg      <= phase_next;
        end
    end

    // limit code goes straight from the mode register flops
    assign ilim_sel_out      = out_mode_reg[OM_ILIM_HI:OM_ILIM_LO];
    assign reg_rdata_out     = rdata_reg;
    assign driver_enable_out = drv_en_reg;
    assign detect_drive_out  = det_drv_reg;
    assign fault_flags_out   = fault_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_ovp_flag_set: assert property (@(posedge clock_in) disable iff (rst)
        clk_en_in && sense_in.ovp |=> fault_reg[FI_OVP] && !drv_en_reg)
        else $error("overvoltage did not latch bit 7");
    a_cout_shared_bit: assert property (@(posedge clock_in) disable iff (rst)
        clk_en_in && drv_en_reg && sense_in.cout_missing |=> fault_reg[FI_OVP])
        else $error("missing capacitor did not latch bit 7");
    a_pin_timeout_lock: assert property (@(posedge clock_in) disable iff (rst)
        clk_en_in && !serial_mode_in && timed_req && timeout_hit && !all_low |=> pin_lock_reg ##0 !drv_en_reg)
        else $error("pin timeout did not lock");
    a_strobe_timeout: assert property (@(posedge clock_in) disable iff (rst)
        clk_en_in && serial_mode_in && timed_req && timeout_hit |=> fault_reg[FI_TIMEOUT])
        else $error("strobe timeout not flagged");
    a_thermal_flag: assert property (@(posedge clock_in) disable iff (rst)
        clk_en_in && sense_in.over_temp |=> fault_reg[FI_TEMP] && !drv_en_reg)
        else $error("overtemperature not flagged");
    a_ilim_code_follow: assert property (@(posedge clock_in) disable iff (rst)
        clk_en_in && reg_req_in.wr && reg_req_in.addr == ADDR_OUT_MODE |=> ilim_sel_out == $past(reg_req_in.wdata[7:6]))
        else $error("peak limit code not taken from write");
    a_ilim_fault_flag: assert property (@(posedge clock_in) disable iff (rst)
        clk_en_in && drv_en_reg && sense_in.ilim_trip |=> fault_reg[FI_ILIM])
        else $error("current limit not flagged");
    a_read_clears_flags: assert property (@(posedge clock_in) disable iff (rst)
        clk_en_in && serial_mode_in && reg_req_in.rd && reg_req_in.addr == ADDR_FAULT && set_bits == 8'h00
        |=> (fault_reg & FAULT_CLR_MASK) == 8'h00 && rdata_reg == $past(fault_reg))
        else $error("fault read did not clear flags");
    a_timer_restart: assert property (@(posedge clock_in) disable iff (rst)
        clk_en_in && !timed_req |=> tmr_reg == '0)
        else $error("timeout counter did not clear");
    a_detect_drive_gate: assert property (@(posedge clock_in) disable iff (rst)
        det_drv_reg |-> drv_en_reg && $past(detect_on) && phase_reg == PH_START)
        else $error("detection current outside startup");
endmodule
`default_nettype wire

// [flash_host_model.sv]
// host side model: register port master and flash control pins
`timescale 1ns/10ps
`default_nettype none
module flash_host_model (
    input  wire logic                 clock_in,   // device clock
    input  wire logic [7:0]           rdata_in,   // register read data
    output var flash_fault_pkg::reg_req_s req_out, // register request
    output var flash_fault_pkg::pins_s pins_out,  // enable, torch, strobe
    output var logic                  serial_out  // high: register mode
);
    import flash_fault_pkg::*;
    // idle bus and low pins at time zero, so no flash is requested
    initial begin
        req_out = '0;
        pins_out = '0;
        serial_out = 1'b1;
    end
    // pins change just after an edge so the device never sees a race
    task automatic drive(input pins_s p, input logic ser);
        @(posedge clock_in);
        #1;
        pins_out = p;
        serial_out = ser;
    endtask
    // one-cycle write strobe; the port has no wait state
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        #1;
        req_out = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge clock_in);
        #1;
        req_out.wr = 1'b0;
    endtask
    // read data is registered at the taking edge; in register mode reading faults clears them
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_in);
        #1;
        req_out = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge clock_in);
        #1;
        req_out.rd = 1'b0;
        d = rdata_in;
    endtask
endmodule
`default_nettype wire

// [flash_fault_protection_bench.sv]
// self-checking bench for the flash fault supervisor
`timescale 1ns/10ps
`default_nettype none
module flash_fault_protection_bench;
    import flash_fault_pkg::*;
    localparam int TO_CYC = 50; // short flash limit keeps the run brief
    logic       clock_in;
    logic       sys_rst_in;
    logic       lockout;
    sense_s     sense;
    reg_req_s   req;
    pins_s      pins;
    logic       serial;
    logic [7:0] rdata;
    logic       drv_en;
    logic       det_drv;
    logic [1:0] ilim_sel;
    logic [7:0] flags;
    logic [7:0] rv;
    int         n_fail;
    int         cmp_count;
    // ------------------------------------------------------------
    // device and host
    // ------------------------------------------------------------
    flash_fault_protection #(.TIMEOUT_CYCLES(TO_CYC)) flash_fault_protection_i (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .clk_en_in(1'b1),
        .input_undervoltage_lockout_in(lockout), .serial_mode_in(serial),
        .pins_in(pins), .sense_in(sense), .reg_req_in(req), .reg_rdata_out(rdata),
        .driver_enable_out(drv_en), .detect_drive_out(det_drv),
        .ilim_sel_out(ilim_sel), .fault_flags_out(flags));
    flash_host_model flash_host_model_i (
        .clock_in(clock_in), .rdata_in(rdata), .req_out(req),
        .pins_out(pins), .serial_out(serial));
    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    // bounded wait on the driver enable or the detection drive
    task automatic wait_sig(input bit det, input logic lvl, input int bound);
        for (int i = 0; i < bound; i++) begin
            if ((det ? det_drv : drv_en) === lvl)
                return;
            cyc(1);
        end
        n_fail++;
        $display("[ERR] t=%0t wait expired det=%h lvl=%h", $time, det, lvl);
        conclude();
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        flash_host_model_i.rd(a, rv);
        chk(rv, exp);
    endtask
    // one-cycle comparator pulse, flag expected right after it
    task automatic pulse(input sense_s s);
        sense = s;
        cyc(1);
        sense = '0;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rdchk(ADDR_OUT_MODE, 8'hb4);
        rdchk(ADDR_FAULT, 8'h08);
        rdchk(ADDR_IN_CTRL, 8'h06);
        rdchk(8'h07, 8'h00);
        chk({6'h00, ilim_sel}, 8'h02);
        flash_host_model_i.wr(ADDR_FAULT, 8'hf7);
        rdchk(ADDR_FAULT, 8'h00);
        flash_host_model_i.wr(ADDR_IN_CTRL, 8'hff);
        rdchk(ADDR_IN_CTRL, 8'h06);
        flash_host_model_i.wr(ADDR_OUT_MODE, 8'h74);
        cyc(1);
        chk({6'h00, ilim_sel}, 8'h01);
        $display("register map test done");
    endtask
    task automatic t_faults();
        pulse('{over_temp: 1'b1, default: 1'b0});
        chk(flags, 8'h20);
        pulse('{cout_missing: 1'b1, default: 1'b0});
        chk(flags, 8'h20);
        pulse('{ovp: 1'b1, default: 1'b0});
        chk(flags, 8'ha0);
        rdchk(ADDR_FAULT, 8'ha0);
        chk(flags, 8'h00);
        $display("latched fault test done");
    endtask
    task automatic t_detect();
        sense = '{vf_high: 1'b1, default: 1'b0};
        flash_host_model_i.wr(ADDR_OUT_MODE, 8'h7b);
        wait_sig(1'b1, 1'b1, 10);
        wait_sig(1'b1, 1'b0, 250);
        cyc(1);
        chk(flags, 8'h08);
        sense = '0;
        wait_sig(1'b0, 1'b1, 10);
        pulse('{ilim_trip: 1'b1, default: 1'b0});
        chk({7'h00, drv_en}, 8'h00);
        rdchk(ADDR_FAULT, 8'h0a);
        wait_sig(1'b0, 1'b1, 10);
        pulse('{cout_missing: 1'b1, default: 1'b0});
        chk(flags, 8'h88);
        rdchk(ADDR_FAULT, 8'h88);
        flash_host_model_i.wr(ADDR_OUT_MODE, 8'h70);
        flash_host_model_i.wr(ADDR_OUT_MODE, 8'h73);
        cyc(3);
        chk({7'h00, det_drv}, 8'h00);
        flash_host_model_i.wr(ADDR_OUT_MODE, 8'h70);
        sense = '{led_short: 1'b1, default: 1'b0};
        flash_host_model_i.wr(ADDR_OUT_MODE, 8'h7b);
        wait_sig(1'b1, 1'b1, 10);
        wait_sig(1'b1, 1'b0, 250);
        cyc(1);
        chk(flags, 8'h40);
        chk({7'h00, drv_en}, 8'h00);
        sense = '0;
        flash_host_model_i.wr(ADDR_OUT_MODE, 8'h74);
        rdchk(ADDR_FAULT, 8'h40);
        $display("detection test done");
    endtask
    task automatic t_timeout();
        flash_host_model_i.drive('{strobe: 1'b1, default: 1'b0}, 1'b1);
        cyc(TO_CYC - 10);
        flash_host_model_i.drive('0, 1'b1);
        cyc(2);
        flash_host_model_i.drive('{strobe: 1'b1, default: 1'b0}, 1'b1);
        cyc(TO_CYC - 10);
        chk(flags, 8'h00);
        cyc(20);
        chk(flags, 8'h10);
        chk({7'h00, drv_en}, 8'h00);
        flash_host_model_i.drive('0, 1'b1);
        rdchk(ADDR_FAULT, 8'h10);
        flash_host_model_i.wr(ADDR_IN_CTRL, 8'h02);
        cyc(TO_CYC + 10);
        chk(flags, 8'h10);
        flash_host_model_i.wr(ADDR_IN_CTRL, 8'h06);
        rdchk(ADDR_FAULT, 8'h10);
        // edge mode: one rising edge starts a flash that outlasts the strobe
        flash_host_model_i.wr(ADDR_OUT_MODE, 8'h54);
        flash_host_model_i.drive('{strobe: 1'b1, default: 1'b0}, 1'b1);
        flash_host_model_i.drive('0, 1'b1);
        cyc(2);
        chk({7'h00, drv_en}, 8'h01);
        flash_host_model_i.wr(ADDR_OUT_MODE, 8'h74);
        cyc(1);
        chk({7'h00, drv_en}, 8'h00);
        $display("flash timeout test done");
    endtask
    task automatic t_pins();
        flash_host_model_i.drive('{flash_enable_a: 1'b1, flash_enable_b: 1'b1, default: 1'b0}, 1'b0);
        wait_sig(1'b0, 1'b1, 10);
        cyc(TO_CYC + 10);
        chk({7'h00, drv_en}, 8'h00);
        chk(flags, 8'h00);
        flash_host_model_i.drive('{flash_enable_b: 1'b1, default: 1'b0}, 1'b0);
        cyc(5);
        chk({7'h00, drv_en}, 8'h00);
        flash_host_model_i.drive('0, 1'b0);
        cyc(2);
        flash_host_model_i.drive('{torch: 1'b1, default: 1'b0}, 1'b0);
        wait_sig(1'b0, 1'b1, 10);
        wait_sig(1'b1, 1'b1, 10);
        flash_host_model_i.drive('0, 1'b1);
        $display("pin mode test done");
    endtask
    task automatic t_input_undervoltage_lockout();
        flash_host_model_i.wr(ADDR_OUT_MODE, 8'h00);
        pulse('{over_temp: 1'b1, default: 1'b0});
        chk(flags, 8'h20);
        lockout = 1'b1;
        cyc(2);
        lockout = 1'b0;
        chk(flags, 8'h08);
        rdchk(ADDR_OUT_MODE, 8'hb4);
        $display("undervoltage test done");
    endtask
    // ------------------------------------------------------------
    // clock and main sequence
    // ------------------------------------------------------------
    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end
    initial begin
        sys_rst_in = 1'b1;
        lockout = 1'b0;
        sense = '0;
        n_fail = 0;
        cmp_count = 0;
        repeat (6) @(posedge clock_in);
        #1;
        sys_rst_in = 1'b0;
        t_reset();
        t_faults();
        t_detect();
        t_timeout();
        t_pins();
        t_input_undervoltage_lockout();
        conclude();
    end
endmodule
`default_nettype wire
